// file: hdl/sixirq_pkg.sv
/*
 package of the six-source interrupt priority unit: register offsets, field positions,
 reset values, vector addresses and shared types.
 assumes a core that reads registers over a plain strobe port.
*/
package sixirq_pkg;
	localparam int NUM_SRC = 6;
	// source index order is also the polling order within a level
	localparam int SRC_EXT_A = 0;
	localparam int SRC_TMR_A = 1;
	localparam int SRC_EXT_B = 2;
	localparam int SRC_TMR_B = 3;
	localparam int SRC_SERIAL = 4;
	localparam int SRC_TMR_C = 5;
	localparam logic [3:0] OFS_TIMER_CONTROL = 4'h0;
	localparam logic [3:0] OFS_IRQ_ENABLE = 4'h1;
	localparam logic [3:0] OFS_PRIO_LOW = 4'h2;
	localparam logic [3:0] OFS_PRIO_HIGH = 4'h3;
	localparam logic [3:0] OFS_SERIAL_FLAGS = 4'h4;
	localparam logic [3:0] OFS_TIMER_C_FLAGS = 4'h5;
	localparam logic [3:0] OFS_STATUS = 4'h6;
	// timer control, enable, serial flag and timer c flag bit positions
	localparam int TC_EXT_A_EDGE = 0;
	localparam int TC_EXT_A_FLAG = 1;
	localparam int TC_EXT_B_EDGE = 2;
	localparam int TC_EXT_B_FLAG = 3;
	localparam int TC_TMR_A_FLAG = 5;
	localparam int TC_TMR_B_FLAG = 7;
	localparam int IE_GLOBAL = 7;
	localparam int SER_TX = 1;
	localparam int SER_RX = 0;
	localparam int TC_C_OVF = 7;
	localparam int TC_C_EXT = 6;
	localparam logic [7:0] TIMER_CONTROL_RESET = 8'h00;
	localparam logic [7:0] IRQ_ENABLE_RESET = 8'h00;
	localparam logic [7:0] PRIO_RESET = 8'h00;
	localparam logic [7:0] ENABLE_MASK = 8'hbf;
	localparam logic [7:0] PRIO_MASK = 8'h3f;
	localparam logic [15:0] VECTOR_BASE = 16'h0003;
	localparam logic [15:0] VECTOR_STEP = 16'h0008;
	localparam int MACHINE_CYCLE_CLOCKS = 12;
	localparam logic [1:0] LEVEL_TOP = 2'h3;

	typedef struct packed {
		logic [3:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} sixirq_bus_t;

	typedef struct packed {
		logic timerAOverflow;
		logic timerBOverflow;
		logic timerCOverflow;
		logic timerCExternal;
		logic serialRxDone;
		logic serialTxDone;
	} sixirq_events_t;
endpackage

// file: hdl/sixirq_arbiter.sv
/*
 priority resolver: picks the winning source from pending flags and levels.
 assumes the flags handed in are already sampled and enabled.
*/
`timescale 1ns/10ps
`default_nettype none
module sixirq_arbiter #(
	parameter int N = 6
) (
	input wire logic [N-1:0] pending,
	input wire logic [2*N-1:0] levels,
	output logic found,
	output logic [2:0] winner,
	output logic [1:0] winLevel
);
	always_comb
	begin
		found = 1'b0;
		winner = 3'h0;
		winLevel = 2'h0;
		for (int lv = 3; lv >= 0; lv--)
		begin
			for (int s = N - 1; s >= 0; s--)
			begin
				if (!found && pending[s] && levels[2*s +: 2] == 2'(lv))
				begin
					winner = 3'(s);
				end
			end
			if (!found)
			begin
				for (int s = 0; s < N; s++)
				begin
					if (pending[s] && levels[2*s +: 2] == 2'(lv))
					begin
						found = 1'b1;
						winLevel = 2'(lv);
					end
				end
			end
		end
	end
endmodule
`default_nettype wire

// file: hdl/sixirq_unit.sv
/*
 six-source interrupt priority unit: request flags, enables, four-level priority,
 nesting stack and vector call request toward the core.
 assumes the core gives instruction-end and blocking-instruction flags, and
 acknowledges a vector call with a one-cycle pulse.
*/
// Decided for this implementation: the address-and-strobe port and the placing of the registers.
// How it works
// - six sources: two pins, two timer overflows, serial, third timer.
// - each external pin level or edge triggered by its own control bit.
// - edge-triggered external flag cleared when its vector is taken.
// - level mode: external flag simply follows the pin each cycle.
// - timer overflow pulses set the first two timer flags.
// - timer a and timer b overflow flags cleared when their vector is taken; timer c flags are left alone.
// - serial request is receive-done OR transmit-done.
// - serial flags are left alone when the serial vector is taken.
// - software writes to flags act just like hardware events.
// - each source gated by its own enable bit.
// - global enable cleared blocks all sources.
// - two priority registers give one bit each per source.
// - higher level request may preempt a lower running routine.
// - same-level request never preempts the running routine.
// - a level-3 routine is never preempted.
// - higher level wins among simultaneous requests.
// - fixed polling order resolves same-level ties.
// - order: ext a, timer a, ext b, timer b, serial, timer c.
// - flags sampled once per machine cycle, evaluated the next cycle.
// - call held off by active level, mid-instruction, return or enable write.
// - blocked request is not remembered; each poll is fresh.
`timescale 1ns/10ps
`default_nettype none
module sixirq_unit #(
	parameter int CYCLE_CLOCKS = sixirq_pkg::MACHINE_CYCLE_CLOCKS
) (
	input wire logic sys_clk,
	input wire logic reset,
	input wire sixirq_pkg::sixirq_bus_t bus,
	output logic [7:0] rdata,
	input wire logic ext_irq_pin_a,
	input wire logic ext_irq_pin_b,
	input wire sixirq_pkg::sixirq_events_t events,
	input wire logic instrLastCycle,
	input wire logic instrBlocks,
	input wire logic retiDone,
	input wire logic vectorAck,
	output logic vectorReq,
	output logic [15:0] vectorAddr,
	output logic [2:0] vectorSource,
	output logic machineCycle
);
	localparam int CW = $clog2(CYCLE_CLOCKS + 1);
	logic [7:0] timer_control_reg, timerControlNext;
	logic [7:0] irq_enable_reg, irqEnableNext;
	logic [7:0] priority_low_bits_reg, prioLowNext;
	logic [7:0] priority_high_bits_reg, prioHighNext;
	logic [1:0] serialFlags_reg, serialFlagsNext;
	logic [1:0] timerCFlags_reg, timerCFlagsNext;
	logic pinA_reg, pinB_reg;
	logic [CW-1:0] divCount_reg, divCountNext;
	logic [5:0] sampled_reg, sampledNext;
	logic [3:0] active_reg, activeNext;
	logic vectorReq_reg, vectorReqNext;
	logic [2:0] vecSrc_reg, vecSrcNext;
	logic [15:0] vecAddr_reg, vecAddrNext;
	logic [7:0] rdata_reg, rdataNext;
	logic [5:0] flags, enabled, pendingNow;
	logic [11:0] levels;
	logic found, tick, blocked, wrFlag;
	logic [2:0] winner;
	logic [1:0] winLevel;
	logic [1:0] runLevel;
	logic anyActive;

	function automatic logic wrHit(input sixirq_pkg::sixirq_bus_t b, input logic [3:0] ofs);
		wrHit = b.wr && b.addr == ofs;
	endfunction

	function automatic logic [1:0] topLevel(input logic [3:0] act);
		topLevel = 2'h0;
		for (int i = 0; i < 4; i++)
		begin
			if (act[i])
			begin
				topLevel = 2'(i);
			end
		end
	endfunction

	assign flags = {
		timerCFlags_reg[sixirq_pkg::SER_TX] | timerCFlags_reg[sixirq_pkg::SER_RX],
		serialFlags_reg[sixirq_pkg::SER_TX] | serialFlags_reg[sixirq_pkg::SER_RX],
		timer_control_reg[sixirq_pkg::TC_TMR_B_FLAG],
		timer_control_reg[sixirq_pkg::TC_EXT_B_FLAG],
		timer_control_reg[sixirq_pkg::TC_TMR_A_FLAG],
		timer_control_reg[sixirq_pkg::TC_EXT_A_FLAG]
	};
	assign enabled = irq_enable_reg[sixirq_pkg::IE_GLOBAL] ? irq_enable_reg[5:0] : 6'h00;
	assign pendingNow = sampled_reg & enabled;
	genvar g;
	generate
		for (g = 0; g < 6; g++)
		begin : gLevel
			assign levels[2*g +: 2] = {priority_high_bits_reg[g], priority_low_bits_reg[g]};
		end
	endgenerate

	sixirq_arbiter #(
		.N(6)
	) arbiter (
		.pending(pendingNow),
		.levels(levels),
		.found(found),
		.winner(winner),
		.winLevel(winLevel)
	);

	assign tick = divCount_reg == CW'(CYCLE_CLOCKS - 1);
	assign anyActive = |active_reg;
	assign runLevel = topLevel(active_reg);
	assign blocked = (anyActive && (winLevel <= runLevel || active_reg[sixirq_pkg::LEVEL_TOP]))
		|| !instrLastCycle || instrBlocks || vectorReq_reg;
	assign wrFlag = bus.wr;

	always_comb
	begin
		divCountNext = tick ? '0 : divCount_reg + CW'(1);
		timerControlNext = timer_control_reg;
		serialFlagsNext = serialFlags_reg;
		timerCFlagsNext = timerCFlags_reg;
		irqEnableNext = irq_enable_reg;
		prioLowNext = priority_low_bits_reg;
		prioHighNext = priority_high_bits_reg;
		// vector taken: clear edge and timer a/b flags, serial and timer c untouched; a same-cycle set wins
		if (vectorAck && vectorReq_reg)
		begin
			case (vecSrc_reg)
				3'h0: if (timer_control_reg[sixirq_pkg::TC_EXT_A_EDGE])
					timerControlNext[sixirq_pkg::TC_EXT_A_FLAG] = 1'b0;
				3'h1: timerControlNext[sixirq_pkg::TC_TMR_A_FLAG] = 1'b0;
				3'h2: if (timer_control_reg[sixirq_pkg::TC_EXT_B_EDGE])
					timerControlNext[sixirq_pkg::TC_EXT_B_FLAG] = 1'b0;
				3'h3: timerControlNext[sixirq_pkg::TC_TMR_B_FLAG] = 1'b0;
				default: serialFlagsNext = serialFlagsNext;
			endcase
		end
		// hardware events set flags
		if (events.timerAOverflow)
			timerControlNext[sixirq_pkg::TC_TMR_A_FLAG] = 1'b1;
		if (events.timerBOverflow)
			timerControlNext[sixirq_pkg::TC_TMR_B_FLAG] = 1'b1;
		if (events.serialRxDone)
			serialFlagsNext[sixirq_pkg::SER_RX] = 1'b1;
		if (events.serialTxDone)
			serialFlagsNext[sixirq_pkg::SER_TX] = 1'b1;
		if (events.timerCOverflow)
			timerCFlagsNext[1] = 1'b1;
		if (events.timerCExternal)
			timerCFlagsNext[0] = 1'b1;
		if (timer_control_reg[sixirq_pkg::TC_EXT_A_EDGE])
		begin
			if (pinA_reg && !ext_irq_pin_a)
				timerControlNext[sixirq_pkg::TC_EXT_A_FLAG] = 1'b1;
		end
		if (timer_control_reg[sixirq_pkg::TC_EXT_B_EDGE])
		begin
			if (pinB_reg && !ext_irq_pin_b)
				timerControlNext[sixirq_pkg::TC_EXT_B_FLAG] = 1'b1;
		end
		// software writes act like hardware
		if (wrFlag && bus.addr == sixirq_pkg::OFS_TIMER_CONTROL)
			timerControlNext = bus.wdata;
		if (wrHit(bus, sixirq_pkg::OFS_SERIAL_FLAGS))
			serialFlagsNext = bus.wdata[1:0];
		if (wrHit(bus, sixirq_pkg::OFS_TIMER_C_FLAGS))
			timerCFlagsNext = {bus.wdata[sixirq_pkg::TC_C_OVF], bus.wdata[sixirq_pkg::TC_C_EXT]};
		if (wrHit(bus, sixirq_pkg::OFS_IRQ_ENABLE))
			irqEnableNext = bus.wdata & sixirq_pkg::ENABLE_MASK;
		if (wrHit(bus, sixirq_pkg::OFS_PRIO_LOW))
			prioLowNext = bus.wdata & sixirq_pkg::PRIO_MASK;
		if (wrHit(bus, sixirq_pkg::OFS_PRIO_HIGH))
			prioHighNext = bus.wdata & sixirq_pkg::PRIO_MASK;
		// level mode follows the pin, low active
		if (!timer_control_reg[sixirq_pkg::TC_EXT_A_EDGE])
			timerControlNext[sixirq_pkg::TC_EXT_A_FLAG] = !ext_irq_pin_a;
		if (!timer_control_reg[sixirq_pkg::TC_EXT_B_EDGE])
			timerControlNext[sixirq_pkg::TC_EXT_B_FLAG] = !ext_irq_pin_b;
	end

	always_comb
	begin
		sampledNext = tick ? flags : sampled_reg;
		activeNext = active_reg;
		vectorReqNext = vectorReq_reg;
		vecSrcNext = vecSrc_reg;
		vecAddrNext = vecAddr_reg;
		if (retiDone)
			activeNext[runLevel] = 1'b0;
		if (vectorReq_reg && vectorAck)
		begin
			vectorReqNext = 1'b0;
			activeNext[levels[2*vecSrc_reg +: 2]] = 1'b1;
		end
		// every poll is fresh: only current samples count
		else if (tick && found && !blocked)
		begin
			vectorReqNext = 1'b1;
			vecSrcNext = winner;
			vecAddrNext = sixirq_pkg::VECTOR_BASE + 16'(winner) * sixirq_pkg::VECTOR_STEP;
		end
	end

	always_comb
	begin
		rdataNext = 8'h00;
		if (bus.rd)
		begin
			if (bus.addr == sixirq_pkg::OFS_TIMER_CONTROL)
				rdataNext = timer_control_reg;
			else if (bus.addr == sixirq_pkg::OFS_IRQ_ENABLE)
				rdataNext = irq_enable_reg;
			else if (bus.addr == sixirq_pkg::OFS_PRIO_LOW)
				rdataNext = priority_low_bits_reg;
			else if (bus.addr == sixirq_pkg::OFS_PRIO_HIGH)
				rdataNext = priority_high_bits_reg;
			else if (bus.addr == sixirq_pkg::OFS_SERIAL_FLAGS)
				rdataNext = {6'h00, serialFlags_reg};
			else if (bus.addr == sixirq_pkg::OFS_TIMER_C_FLAGS)
				rdataNext = {timerCFlags_reg, 6'h00};
			else if (bus.addr == sixirq_pkg::OFS_STATUS)
				rdataNext = {vectorReq_reg, vecSrc_reg, active_reg};
		end
	end

	// registers, flags, pin history and divider
	always_ff @(posedge sys_clk or posedge reset)
	begin
		if (reset)
		begin
			timer_control_reg <= sixirq_pkg::TIMER_CONTROL_RESET;
			irq_enable_reg <= sixirq_pkg::IRQ_ENABLE_RESET;
			priority_low_bits_reg <= sixirq_pkg::PRIO_RESET;
			priority_high_bits_reg <= sixirq_pkg::PRIO_RESET;
			serialFlags_reg <= 2'h0;
			timerCFlags_reg <= 2'h0;
			pinA_reg <= 1'b1;
			pinB_reg <= 1'b1;
			divCount_reg <= '0;
		end
		else
		begin
			timer_control_reg <= timerControlNext;
			irq_enable_reg <= irqEnableNext;
			priority_low_bits_reg <= prioLowNext;
			priority_high_bits_reg <= prioHighNext;
			serialFlags_reg <= serialFlagsNext;
			timerCFlags_reg <= timerCFlagsNext;
			pinA_reg <= ext_irq_pin_a;
			pinB_reg <= ext_irq_pin_b;
			divCount_reg <= divCountNext;
		end
	end

	// poll sample, active levels and vector call
	always_ff @(posedge sys_clk or posedge reset)
	begin
		if (reset)
		begin
			sampled_reg <= 6'h00;
			active_reg <= 4'h0;
			vectorReq_reg <= 1'b0;
			vecSrc_reg <= 3'h0;
			vecAddr_reg <= 16'h0000;
		end
		else
		begin
			sampled_reg <= sampledNext;
			active_reg <= activeNext;
			vectorReq_reg <= vectorReqNext;
			vecSrc_reg <= vecSrcNext;
			vecAddr_reg <= vecAddrNext;
		end
	end

	always_ff @(posedge sys_clk or posedge reset)
	begin
		if (reset)
		begin
			rdata_reg <= 8'h00;
		end
		else
		begin
			rdata_reg <= rdataNext;
		end
	end

	assign rdata = rdata_reg;
	assign vectorReq = vectorReq_reg;
	assign vectorAddr = vecAddr_reg;
	assign vectorSource = vecSrc_reg;
	assign machineCycle = tick;
endmodule
`default_nettype wire

// file: verification/sixirq_unit_sva.sv
/*
 checker of the vector call, sampling tick and enable relations of the unit.
 assumes it is bound to sixirq_unit and sees only its ports.
*/
`timescale 1ns/10ps
`default_nettype none
module sixirq_unit_sva #(
	parameter int CYCLE_CLOCKS = 12
) (
	input wire logic sys_clk,
	input wire logic reset,
	input wire sixirq_pkg::sixirq_bus_t bus,
	input wire logic instrLastCycle,
	input wire logic instrBlocks,
	input wire logic retiDone,
	input wire logic vectorAck,
	input wire logic vectorReq,
	input wire logic [15:0] vectorAddr,
	input wire logic [2:0] vectorSource,
	input wire logic machineCycle
);
	logic [7:0] enMask_reg, prioLo_reg, prioHi_reg, tickGap_reg, enLate_reg;
	logic ticked_reg, top3_reg;
	always_ff @(posedge sys_clk or posedge reset)
	begin
		if (reset)
		begin
			{enMask_reg, prioLo_reg, prioHi_reg, tickGap_reg, enLate_reg} <= 40'h00_0000_0000;
			{ticked_reg, top3_reg} <= 2'h0;
		end
		else
		begin
			if (bus.wr && bus.addr == sixirq_pkg::OFS_IRQ_ENABLE)
				enMask_reg <= bus.wdata;
			if (bus.wr && bus.addr == sixirq_pkg::OFS_PRIO_LOW)
				prioLo_reg <= bus.wdata;
			if (bus.wr && bus.addr == sixirq_pkg::OFS_PRIO_HIGH)
				prioHi_reg <= bus.wdata;
			tickGap_reg <= machineCycle ? 8'h00 : tickGap_reg + 8'h01;
			enLate_reg <= enMask_reg;
			ticked_reg <= ticked_reg | machineCycle;
			if (vectorReq && vectorAck && prioHi_reg[vectorSource] && prioLo_reg[vectorSource])
				top3_reg <= 1'b1;
			else if (retiDone)
				top3_reg <= 1'b0;
		end
	end
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (reset);
	property p_tick_gap;
		machineCycle && ticked_reg |-> tickGap_reg == 8'(CYCLE_CLOCKS - 1);
	endproperty
	a_tick_gap: assert property (p_tick_gap) else $error("tick spacing off");
	property p_req_tick;
		$rose(vectorReq) |-> $past(machineCycle);
	endproperty
	a_req_tick: assert property (p_req_tick) else $error("call off tick");
	property p_req_ready;
		$rose(vectorReq) |-> $past(instrLastCycle) && !$past(instrBlocks);
	endproperty
	a_req_ready: assert property (p_req_ready) else $error("call while held");
	property p_req_hold;
		vectorReq && !vectorAck |=> vectorReq;
	endproperty
	a_req_hold: assert property (p_req_hold) else $error("call dropped");
	property p_ack_drop;
		vectorReq && vectorAck |=> !vectorReq;
	endproperty
	a_ack_drop: assert property (p_ack_drop) else $error("call kept");
	property p_vec_addr;
		vectorReq |-> vectorSource < 3'h6 && vectorAddr == 16'h0003 + 16'h0008 * vectorSource;
	endproperty
	a_vec_addr: assert property (p_vec_addr) else $error("bad vector");
	property p_global;
		$rose(vectorReq) |-> enLate_reg[7];
	endproperty
	a_global: assert property (p_global) else $error("call while global off");
	property p_enabled;
		$rose(vectorReq) |-> enLate_reg[vectorSource];
	endproperty
	a_enabled: assert property (p_enabled) else $error("call of disabled source");
	property p_top3;
		top3_reg |-> !$rose(vectorReq);
	endproperty
	a_top3: assert property (p_top3) else $error("top level preempted");
	c_serial: cover property ($rose(vectorReq) && vectorSource == 3'h4);
	c_timer_c: cover property ($rose(vectorReq) && vectorSource == 3'h5);
	c_top_end: cover property (top3_reg && retiDone);
endmodule
`default_nettype wire

// file: verification/sixirq_core_model.sv
/*
 core model: marks instruction ends, blocking instructions and acks calls.
 assumes the unit's tick and vector call outputs.
*/
`timescale 1ns/10ps
`default_nettype none
module sixirq_core_model (
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic machineCycle,
	input wire logic vectorReq,
	input wire logic [1:0] instrLen,
	input wire logic [3:0] ackWait,
	input wire logic blocking,
	output logic instrLastCycle,
	output logic instrBlocks,
	output logic vectorAck
);
	logic [1:0] phase_reg;
	logic [3:0] wait_reg;
	always_ff @(posedge sys_clk or posedge reset)
	begin
		if (reset)
		begin
			{phase_reg, wait_reg, vectorAck} <= 7'h00;
		end
		else
		begin
			if (machineCycle)
				phase_reg <= instrLastCycle ? 2'h0 : phase_reg + 2'h1;
			wait_reg <= vectorReq && !vectorAck ? wait_reg + 4'h1 : 4'h0;
			vectorAck <= vectorReq && !vectorAck && wait_reg >= ackWait;
		end
	end
	assign instrLastCycle = phase_reg >= instrLen;
	assign instrBlocks = blocking;
endmodule
`default_nettype wire

// file: verification/six_source_interrupt_priority_unit_tb_top.sv
/*
 testbench of the interrupt unit: register tasks and call sequences.
 assumes the core model and the bound checker.
*/
`timescale 1ns/10ps
`default_nettype none
module six_source_interrupt_priority_unit_tb_top;
	logic sys_clk = 1'b0;
	logic reset = 1'b1;
	sixirq_pkg::sixirq_bus_t bus = '0;
	sixirq_pkg::sixirq_events_t events = '0;
	logic ext_irq_pin_a = 1'b1;
	logic ext_irq_pin_b = 1'b1;
	logic retiDone = 1'b0;
	logic blocking = 1'b0;
	logic [1:0] instrLen = 2'h0;
	logic [3:0] ackWait = 4'h2;
	logic instrLastCycle, instrBlocks, vectorAck, vectorReq, machineCycle;
	logic [7:0] rdata;
	logic [15:0] vectorAddr;
	logic [2:0] vectorSource;
	int errors = 0;
	int nCompared = 0;
	sixirq_unit #(.CYCLE_CLOCKS(4)) dut (.sys_clk, .reset, .bus, .rdata, .ext_irq_pin_a,
		.ext_irq_pin_b, .events, .instrLastCycle, .instrBlocks, .retiDone, .vectorAck,
		.vectorReq, .vectorAddr, .vectorSource, .machineCycle);
	sixirq_core_model core (.sys_clk, .reset, .machineCycle, .vectorReq, .instrLen,
		.ackWait, .blocking, .instrLastCycle, .instrBlocks, .vectorAck);
	initial
	begin
		forever #4 sys_clk = ~sys_clk;
	end
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		nCompared++;
		if (seen !== exp)
		begin
			errors++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic report_and_stop;
		if (errors == 0 && nCompared > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge sys_clk);
		bus.wr <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, input logic [7:0] exp);
		@(posedge sys_clk);
		bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge sys_clk);
		bus.rd <= 1'b0;
		#1 check("rdata", {8'h00, rdata}, {8'h00, exp});
	endtask
	task automatic waitReq(input logic want);
		int n;
		n = 0;
		while (vectorReq !== want)
		begin
			@(posedge sys_clk);
			#1 n++;
			if (n > 200)
			begin
				check("vectorReq", {15'h0, vectorReq}, {15'h0, want});
				report_and_stop();
			end
		end
	endtask
	task automatic call(input logic [2:0] src);
		waitReq(1'b1);
		check("vectorSource", {13'h0, vectorSource}, {13'h0, src});
		check("vectorAddr", vectorAddr, 16'h0003 + 16'h0008 * src);
		waitReq(1'b0);
	endtask
	task automatic quiet;
		repeat (24)
		begin
			@(posedge sys_clk);
			#1 check("vectorReq", {15'h0, vectorReq}, 16'h0000);
		end
	endtask
	task automatic reti;
		repeat (8) @(posedge sys_clk);
		retiDone <= 1'b1;
		@(posedge sys_clk);
		retiDone <= 1'b0;
	endtask
	task automatic pulse(input sixirq_pkg::sixirq_events_t e);
		@(posedge sys_clk);
		events <= e;
		@(posedge sys_clk);
		events <= '0;
	endtask
	initial
	begin
		repeat (3) @(posedge sys_clk);
		reset <= 1'b0;
		rd(4'h0, 8'h00);
		rd(4'h3, 8'h00);
		rd(4'hf, 8'h00);
		wr(4'h1, 8'hff);
		rd(4'h1, 8'hbf);
		wr(4'h2, 8'hff);
		rd(4'h2, 8'h3f);
		wr(4'h2, 8'h00);
		wr(4'h1, 8'h00);
		wr(4'h0, 8'h01);
		@(posedge sys_clk) ext_irq_pin_a <= 1'b0;
		repeat (3) @(posedge sys_clk);
		rd(4'h0, 8'h03);
		wr(4'h1, 8'h81);
		call(3'h0);
		rd(4'h0, 8'h01);
		reti();
		@(posedge sys_clk) ext_irq_pin_b <= 1'b0;
		repeat (3) @(posedge sys_clk);
		rd(4'h0, 8'h09);
		wr(4'h1, 8'h84);
		call(3'h2);
		@(posedge sys_clk) ext_irq_pin_b <= 1'b1;
		repeat (3) @(posedge sys_clk);
		rd(4'h0, 8'h01);
		reti();
		wr(4'h1, 8'h90);
		pulse(6'h02);
		call(3'h4);
		rd(4'h4, 8'h01);
		wr(4'h4, 8'h00);
		reti();
		wr(4'h4, 8'h02);
		call(3'h4);
		wr(4'h4, 8'h00);
		reti();
		wr(4'h1, 8'h80);
		pulse(6'h20);
		quiet();
		wr(4'h1, 8'h02);
		quiet();
		pulse(6'h04);
		rd(4'h5, 8'h40);
		wr(4'h5, 8'h00);
		rd(4'h0, 8'h21);
		wr(4'h1, 8'h82);
		call(3'h1);
		rd(4'h0, 8'h01);
		reti();
		wr(4'h2, 8'h20);
		wr(4'h3, 8'h20);
		wr(4'h1, 8'hbf);
		pulse(6'h18);
		call(3'h5);
		quiet();
		rd(4'h6, 8'h58);
		wr(4'h5, 8'h00);
		reti();
		call(3'h3);
		reti();
		wr(4'h2, 8'h00);
		wr(4'h3, 8'h00);
		wr(4'h0, 8'ha1);
		call(3'h1);
		quiet();
		reti();
		call(3'h3);
		reti();
		wr(4'h2, 8'h02);
		wr(4'h3, 8'h08);
		wr(4'h5, 8'h80);
		call(3'h5);
		wr(4'h0, 8'ha1);
		call(3'h3);
		wr(4'h5, 8'h00);
		reti();
		call(3'h1);
		reti();
		reti();
		blocking <= 1'b1;
		wr(4'h0, 8'h21);
		quiet();
		wr(4'h0, 8'h01);
		repeat (8) @(posedge sys_clk);
		blocking <= 1'b0;
		quiet();
		instrLen <= 2'h2;
		wr(4'h0, 8'h21);
		call(3'h1);
		reti();
		report_and_stop();
	end
endmodule
bind sixirq_unit sixirq_unit_sva #(.CYCLE_CLOCKS(CYCLE_CLOCKS)) chk (.sys_clk, .reset, .bus,
	.instrLastCycle, .instrBlocks, .retiDone, .vectorAck, .vectorReq, .vectorAddr,
	.vectorSource, .machineCycle);
`default_nettype wire
